// ==== design/flash_self_access.sv ====
// flash self-access controller: address, data, control and unlock registers
// assumes the core's register port and the array are on i_ref_clk;
// configuration bits and the external programmer request come from pins
`timescale 1ns/1ps
module flash_self_access
   import flash_self_pkg::*;
#(
   parameter int unsigned PROG_TIME = PROG_TIME_NS
) (
   input wire logic i_ref_clk,                            // instruction clock
   input wire logic i_arst_n,                             // async reset, low
   input wire logic [2:0] i_reg_sel,                      // register select
   input wire logic i_reg_wr,                             // register write strobe
   input wire logic [7:0] i_reg_wdata,                    // register write data
   output logic [7:0] o_reg_rdata,                        // read data, sel of last cycle
   output logic o_core_discard,                           // squash current instruction
   output logic o_core_stall,                             // core halted for erase/write
   input wire logic [1:0] i_write_protect_select,         // protect config pins
   input wire logic i_code_protect,                       // code protect config pin
   input wire logic i_ext_access_req,                     // external programmer request
   output logic o_ext_access_grant,                       // external access allowed
   output logic [flash_self_pkg::ADDR_W-1:0] o_fl_addr,   // read address
   output logic o_fl_calib,                               // read from test area
   output logic o_fl_rd,                                  // read strobe
   input wire logic [flash_self_pkg::DATA_W-1:0] i_fl_rdata, // read word, same cycle
   output logic o_fl_erase,                               // row erase pulse
   output logic o_fl_prog,                                // block program pulse
   output logic [flash_self_pkg::ADDR_W-1:0] o_fl_row_addr, // row base
   output logic [flash_self_pkg::BLOCK_WORDS*flash_self_pkg::DATA_W-1:0] o_fl_wdata // words
);
   import flash_self_pkg::*;

   localparam int unsigned PROG_CYC = (PROG_TIME + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   logic rst_s1_q;
   logic rst_n;
   logic [3:0] cfg_s1_q;
   logic [3:0] cfg_q;
   logic [1:0] wp_sel;
   logic cp_en;
   logic ext_req;
   logic [7:0] data_low_q;
   logic [5:0] data_high_q;
   logic [7:0] addr_low_q;
   logic [3:0] addr_high_q;
   logic calib_q;
   logic allow_q;
   logic wr_q;
   logic rd_q;
   logic rd_wait_q;
   logic fetch;
   logic ctl_wr;
   logic wr_req;
   logic wr_accept;
   logic [ADDR_W-1:0] cur_addr;
   unlock_st_t unl_q;
   prog_if pif ();

   // ----------------------------------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_s1_q <= '0;
         cfg_q <= '0;
      end else begin
         cfg_s1_q <= {i_ext_access_req, i_code_protect, i_write_protect_select};
         cfg_q <= cfg_s1_q;
      end
   end

   assign wp_sel = cfg_q[1:0];
   assign cp_en = cfg_q[2];
   assign ext_req = cfg_q[3];

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_ext_access_grant <= 1'b0;
      end else begin
         o_ext_access_grant <= ext_req && !cp_en;
      end
   end

   // ----------------------------------------------------------------
   // address registers
   // ----------------------------------------------------------------
   assign cur_addr = {addr_high_q, addr_low_q};

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_low_q <= RST_BYTE;
         addr_high_q <= RST_BYTE[3:0];
      end else if (i_reg_wr) begin
         if (i_reg_sel == SEL_ADDR_LOW) begin
            addr_low_q <= i_reg_wdata;
         end
         if (i_reg_sel == SEL_ADDR_HIGH) begin
            addr_high_q <= i_reg_wdata[3:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // data registers: loaded by a read, else by software
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_low_q <= RST_BYTE;
         data_high_q <= RST_BYTE[5:0];
      end else if (fetch) begin
         data_low_q <= i_fl_rdata[7:0];
         data_high_q <= i_fl_rdata[13:8];
      end else if (i_reg_wr) begin
         if (i_reg_sel == SEL_DATA_LOW) begin
            data_low_q <= i_reg_wdata;
         end
         if (i_reg_sel == SEL_DATA_HIGH) begin
            data_high_q <= i_reg_wdata[5:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // unlock key sequence
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         unl_q <= UNL_IDLE;
      end else if (i_reg_wr) begin
         if (i_reg_sel == SEL_UNLOCK && i_reg_wdata == KEY_FIRST) begin
            unl_q <= UNL_FIRST;
         end else if (i_reg_sel == SEL_UNLOCK && i_reg_wdata == KEY_SECOND
                      && unl_q == UNL_FIRST) begin
            unl_q <= UNL_ARMED;
         end else begin
            unl_q <= UNL_IDLE;
         end
      end
   end

   // ----------------------------------------------------------------
   // control register and write start
   // ----------------------------------------------------------------
   assign ctl_wr = i_reg_wr && (i_reg_sel == SEL_CONTROL);
   assign wr_req = ctl_wr && i_reg_wdata[CTL_WR_BIT] && !wr_q && !rd_q;
   assign wr_accept = wr_req && (unl_q == UNL_ARMED) && allow_q
                      && !calib_q && !i_reg_wdata[CTL_CALIB_BIT]
                      && !write_blocked(wp_sel, cur_addr);

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         calib_q <= 1'b0;
         allow_q <= 1'b0;
      end else if (ctl_wr) begin
         calib_q <= i_reg_wdata[CTL_CALIB_BIT];
         allow_q <= i_reg_wdata[CTL_ALLOW_BIT];
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= 1'b0;
      end else if (wr_accept) begin
         wr_q <= 1'b1;
      end else if (pif.done) begin
         wr_q <= 1'b0;
      end
   end

   assign pif.start = wr_accept;
   assign pif.addr = cur_addr;
   assign pif.wdata = {data_high_q, data_low_q};
   assign o_core_stall = pif.stall;

   flash_prog_engine #(
      .PROG_CYC(PROG_CYC)
   ) u_engine (
      .i_clk(i_ref_clk),
      .i_rst_n(rst_n),
      .eng(pif),
      .o_fl_erase(o_fl_erase),
      .o_fl_prog(o_fl_prog),
      .o_fl_row_addr(o_fl_row_addr),
      .o_fl_wdata(o_fl_wdata)
   );

   // ----------------------------------------------------------------
   // read sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q <= 1'b0;
         rd_wait_q <= 1'b0;
      end else if (rd_q) begin
         rd_wait_q <= !rd_wait_q;
         if (rd_wait_q) begin
            rd_q <= 1'b0;
         end
      end else if (ctl_wr && i_reg_wdata[CTL_RD_BIT] && !wr_q) begin
         rd_q <= 1'b1;
      end
   end

   assign fetch = rd_q && rd_wait_q;
   assign o_fl_rd = fetch;
   assign o_core_discard = fetch;
   assign o_fl_addr = cur_addr;
   assign o_fl_calib = calib_q;

   // ----------------------------------------------------------------
   // register read port
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_reg_rdata <= RST_BYTE;
      end else begin
         unique case (i_reg_sel)
            SEL_DATA_LOW: o_reg_rdata <= data_low_q;
            SEL_ADDR_LOW: o_reg_rdata <= addr_low_q;
            SEL_DATA_HIGH: o_reg_rdata <= {2'b00, data_high_q};
            SEL_ADDR_HIGH: o_reg_rdata <= {4'h0, addr_high_q};
            SEL_CONTROL: o_reg_rdata <= {1'b1, calib_q, 3'b000, allow_q, wr_q, rd_q};
            SEL_UNLOCK: o_reg_rdata <= RST_BYTE;
            default: o_reg_rdata <= RST_BYTE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!rst_n);

   property p_set_only;
      $fell(wr_q) |-> $past(pif.done);
   endproperty
   a_set_only: assert property (p_set_only) else $error("write start cleared early");

   property p_wr_done;
      pif.done |=> !wr_q;
   endproperty
   a_wr_done: assert property (p_wr_done) else $error("write start not cleared");

   property p_need_key;
      wr_accept |-> allow_q && unl_q == UNL_ARMED;
   endproperty
   a_need_key: assert property (p_need_key) else $error("write without key or allow");

   property p_refused;
      (wr_req && !allow_q && !wr_q) |=> !wr_q;
   endproperty
   a_refused: assert property (p_refused) else $error("write allowed while disabled");

   property p_calib;
      calib_q |-> !wr_accept;
   endproperty
   a_calib: assert property (p_calib) else $error("write in calibration space");

   property p_calib_new;
      (ctl_wr && i_reg_wdata[CTL_CALIB_BIT]) |-> !wr_accept;
   endproperty
   a_calib_new: assert property (p_calib_new) else $error("write with calibration set");

   property p_protect;
      write_blocked(wp_sel, cur_addr) |-> !wr_accept;
   endproperty
   a_protect: assert property (p_protect) else $error("write to protected region");

   property p_unlock_zero;
      i_reg_sel == SEL_UNLOCK |=> o_reg_rdata == 8'h00;
   endproperty
   a_unlock_zero: assert property (p_unlock_zero) else $error("unlock reads nonzero");

   property p_ctl_fixed;
      i_reg_sel == SEL_CONTROL |=> o_reg_rdata[7] && o_reg_rdata[5:3] == 3'b000;
   endproperty
   a_ctl_fixed: assert property (p_ctl_fixed) else $error("control fixed bits wrong");

   property p_fetch_time;
      $rose(rd_q) |-> !fetch ##1 fetch ##1 !rd_q;
   endproperty
   a_fetch_time: assert property (p_fetch_time) else $error("read fetch slot wrong");

   property p_data_hold;
      (!fetch && !(i_reg_wr && i_reg_sel == SEL_DATA_LOW)) |=> $stable(data_low_q);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("read data changed");

   property p_high_zero;
      i_reg_sel == SEL_DATA_HIGH || i_reg_sel == SEL_ADDR_HIGH
         |=> o_reg_rdata[7:6] == 2'b00;
   endproperty
   a_high_zero: assert property (p_high_zero) else $error("high bits not zero");

   property p_stall;
      $fell(o_core_stall) |-> o_fl_prog == 1'b0 && pif.done;
   endproperty
   a_stall: assert property (p_stall) else $error("stall released wrongly");

   property p_grant;
      o_ext_access_grant |-> $past(cp_en) == 1'b0;
   endproperty
   a_grant: assert property (p_grant) else $error("external access under protect");

   property p_erase_last;
      o_fl_erase |-> wr_q;
   endproperty
   a_erase_last: assert property (p_erase_last) else $error("erase outside write");

   property p_erase_pos;
      pif.start && pif.addr[1:0] != LAST_POS |=> !o_fl_erase ##1 !o_fl_erase;
   endproperty
   a_erase_pos: assert property (p_erase_pos) else $error("erase on buffer-only word");
endmodule

// ==== design/flash_self_pkg.sv ====
// constants, types and decode shared by the flash self-access block
// assumes one instruction-rate clock and an array read that answers in the same cycle
package flash_self_pkg;
   // ----------------------------------------------------------------
   // widths and timing
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 14;
   localparam int BLOCK_WORDS = 4;
   localparam int TIMER_W = 24;
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned PROG_TIME_NS = 4000000;
   localparam logic [1:0] SETUP_CYC = 2'h2;
   localparam logic [1:0] LAST_POS = 2'h3;

   // ----------------------------------------------------------------
   // register selects, bits, reset values, keys
   // ----------------------------------------------------------------
   localparam logic [2:0] SEL_DATA_LOW = 3'h0;
   localparam logic [2:0] SEL_ADDR_LOW = 3'h1;
   localparam logic [2:0] SEL_DATA_HIGH = 3'h2;
   localparam logic [2:0] SEL_ADDR_HIGH = 3'h3;
   localparam logic [2:0] SEL_CONTROL = 3'h4;
   localparam logic [2:0] SEL_UNLOCK = 3'h5;
   localparam int CTL_RD_BIT = 0;
   localparam int CTL_WR_BIT = 1;
   localparam int CTL_ALLOW_BIT = 2;
   localparam int CTL_CALIB_BIT = 6;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;

   typedef enum logic [1:0] {
      UNL_IDLE = 2'b00,
      UNL_FIRST = 2'b01,
      UNL_ARMED = 2'b10
   } unlock_st_t;

   typedef enum logic [1:0] {
      ENG_IDLE = 2'b00,
      ENG_SETUP = 2'b01,
      ENG_BUSY = 2'b10,
      ENG_DONE = 2'b11
   } eng_st_t;

   // protected region per write-protect select; 11 leaves all open
   function automatic logic write_blocked(input logic [1:0] sel, input logic [ADDR_W-1:0] a);
      unique case (sel)
         2'b11: write_blocked = 1'b0;
         2'b10: write_blocked = (a[11:10] == 2'b00);
         2'b01: write_blocked = (a[11] == 1'b0);
         2'b00: write_blocked = 1'b1;
      endcase
   endfunction
endpackage

// ==== design/prog_if.sv ====
// carrier between the register side and the block program engine
// assumes both ends on the same clock
`timescale 1ns/1ps
interface prog_if;
   import flash_self_pkg::*;
   logic start;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic stall;
   logic done;
   modport ctrl (output start, output addr, output wdata, input stall, input done);
   modport engine (input start, input addr, input wdata, output stall, output done);
endinterface

// ==== design/flash_prog_engine.sv ====
// four-word write buffer with setup delay, erase/program timer and stall
// assumes start is a one-cycle pulse, never raised while a job runs
`timescale 1ns/1ps
module flash_prog_engine
   import flash_self_pkg::*;
#(
   parameter int unsigned PROG_CYC = 1000000
) (
   input wire logic i_clk,                        // instruction clock
   input wire logic i_rst_n,                      // synchronised reset
   prog_if.engine eng,                            // job request and status
   output logic o_fl_erase,                       // row erase pulse
   output logic o_fl_prog,                        // four-word program pulse
   output logic [ADDR_W-1:0] o_fl_row_addr,       // row base address
   output logic [BLOCK_WORDS*DATA_W-1:0] o_fl_wdata // buffered words, word 0 low
);
   eng_st_t st_q;
   logic [1:0] setup_q;
   logic [TIMER_W-1:0] tmr_q;
   logic [DATA_W-1:0] buf_q [BLOCK_WORDS];

   // ----------------------------------------------------------------
   // buffer
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < BLOCK_WORDS; i++) begin
            buf_q[i] <= '0;
         end
      end else if (eng.start) begin
         buf_q[eng.addr[1:0]] <= eng.wdata;
      end
   end

   // ----------------------------------------------------------------
   // sequencer and internal timer
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= ENG_IDLE;
         setup_q <= '0;
         tmr_q <= '0;
         o_fl_row_addr <= '0;
      end else begin
         unique case (st_q)
            ENG_IDLE: if (eng.start) begin
               o_fl_row_addr <= {eng.addr[ADDR_W-1:4], 4'h0};
               setup_q <= '0;
               st_q <= (eng.addr[1:0] == LAST_POS) ? ENG_SETUP : ENG_DONE;
            end
            ENG_SETUP: begin
               setup_q <= setup_q + 2'h1;
               if (setup_q == SETUP_CYC - 2'h1) begin
                  tmr_q <= TIMER_W'(PROG_CYC - 1);
                  st_q <= ENG_BUSY;
               end
            end
            ENG_BUSY: begin
               tmr_q <= tmr_q - 1'b1;
               if (tmr_q == '0) begin
                  st_q <= ENG_DONE;
               end
            end
            ENG_DONE: st_q <= ENG_IDLE;
         endcase
      end
   end

   assign eng.stall = (st_q == ENG_BUSY);
   assign eng.done = (st_q == ENG_DONE);
   assign o_fl_erase = (st_q == ENG_SETUP) && (setup_q == SETUP_CYC - 2'h1);
   assign o_fl_prog = (st_q == ENG_BUSY) && (tmr_q == '0);

   generate
      for (genvar g = 0; g < BLOCK_WORDS; g++) begin : g_wd
         assign o_fl_wdata[g*DATA_W +: DATA_W] = buf_q[g];
      end
   endgenerate
endmodule

// ==== dv/flash_array_model.sv ====
// behavioural program flash array: 4K user words and a small test area
// assumes the controller's strobes and addresses share its clock
`timescale 1ns/1ps
module flash_array_model
   import flash_self_pkg::*;
(
   input wire logic i_clk,                                         // instruction clock
   input wire logic [flash_self_pkg::ADDR_W-1:0] i_addr,           // word address
   input wire logic i_calib,                                       // test area select
   input wire logic i_rd,                                          // read strobe
   input wire logic i_erase,                                       // row erase pulse
   input wire logic i_prog,                                        // block program pulse
   input wire logic [flash_self_pkg::ADDR_W-1:0] i_row,            // row base
   input wire logic [flash_self_pkg::BLOCK_WORDS*flash_self_pkg::DATA_W-1:0] i_wdata, // words
   output logic [flash_self_pkg::DATA_W-1:0] o_rdata               // read word
);
   logic [DATA_W-1:0] mem [4096];
   logic tog = 1'b0;

   initial begin
      for (int a = 0; a < 4096; a++) begin
         mem[a] = 14'(a * 13 + 5);
      end
   end

   // outside a read the bus carries a changing pattern, never stale data
   always_comb begin
      if (i_rd !== 1'b1) begin
         o_rdata = tog ? 14'h2aaa : 14'h1555;
      end else if (i_calib) begin
         o_rdata = 14'h2a00 | 14'(i_addr[3:0]);
      end else begin
         o_rdata = mem[i_addr];
      end
   end

   always @(posedge i_clk) begin
      tog <= ~tog;
      if (i_erase === 1'b1) begin
         for (int k = 0; k < 16; k++) begin
            mem[{i_row[11:4], 4'(k)}] <= 14'h3fff;
         end
      end
      if (i_prog === 1'b1) begin
         for (int k = 0; k < 4; k++) begin
            mem[{i_row[11:4], i_addr[3:2], 2'(k)}] <= i_wdata[k*DATA_W +: DATA_W];
         end
      end
   end
endmodule

// ==== dv/tb.sv ====
// register-level bench of the flash self-access controller
// assumes the array model answers reads in the same cycle
`timescale 1ns/1ps
module tb;
   import flash_self_pkg::*;
   localparam int PCYC = 40;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [2:0] sel = 3'h0;
   logic wr = 1'b0;
   logic [7:0] wd = 8'h00;
   logic [1:0] wps = 2'h3;
   logic cp = 1'b0;
   logic ereq = 1'b0;
   logic [7:0] rdata;
   logic discard, stall, grant, fcal, frd, ferase, fprog;
   logic [ADDR_W-1:0] faddr, frow, row_seen;
   logic [DATA_W-1:0] frdata;
   logic [BLOCK_WORDS*DATA_W-1:0] fwd, wd_seen;
   int miscompares = 0;
   int n_tests = 0;
   int stall_cnt = 0;
   int erase_cnt = 0;
   int prog_cnt = 0;
   logic [7:0] v;
   logic [DATA_W-1:0] w [4];

   flash_self_access #(.PROG_TIME(PCYC * 4)) u_flash_self_access (
      .i_ref_clk(clk), .i_arst_n(arst_n), .i_reg_sel(sel), .i_reg_wr(wr),
      .i_reg_wdata(wd), .o_reg_rdata(rdata), .o_core_discard(discard),
      .o_core_stall(stall), .i_write_protect_select(wps), .i_code_protect(cp),
      .i_ext_access_req(ereq), .o_ext_access_grant(grant), .o_fl_addr(faddr),
      .o_fl_calib(fcal), .o_fl_rd(frd), .i_fl_rdata(frdata), .o_fl_erase(ferase),
      .o_fl_prog(fprog), .o_fl_row_addr(frow), .o_fl_wdata(fwd));

   flash_array_model u_flash_array_model (
      .i_clk(clk), .i_addr(faddr), .i_calib(fcal), .i_rd(frd), .i_erase(ferase),
      .i_prog(fprog), .i_row(frow), .i_wdata(fwd), .o_rdata(frdata));

   always #2 clk = ~clk;

   always @(posedge clk) begin
      if (stall === 1'b1) begin
         stall_cnt <= stall_cnt + 1;
      end
      if (ferase === 1'b1) begin
         erase_cnt <= erase_cnt + 1;
         row_seen <= frow;
      end
      if (fprog === 1'b1) begin
         prog_cnt <= prog_cnt + 1;
         wd_seen <= fwd;
      end
   end

   // ----------------------------------------------------------------
   // checks and bus tasks
   // ----------------------------------------------------------------
   function automatic logic [13:0] pat(input logic [11:0] a);
      return 14'(a * 13 + 5);
   endfunction

   task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_sig(input string nm, input logic [63:0] e, input logic [63:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic reg_wr(input logic [2:0] s, input logic [7:0] d);
      @(negedge clk);
      sel = s;
      wd = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask

   task automatic reg_rd(input logic [2:0] s, output logic [7:0] d);
      @(negedge clk);
      sel = s;
      @(negedge clk);
      d = rdata;
   endtask

   task automatic flash_read(input logic [11:0] a, input logic [7:0] ctl, input logic [13:0] e);
      logic [7:0] lo, hi;
      reg_wr(SEL_ADDR_HIGH, {4'h0, a[11:8]});
      reg_wr(SEL_ADDR_LOW, a[7:0]);
      reg_wr(SEL_CONTROL, ctl);
      chk_sig("discard_early", 64'h0, discard);
      @(negedge clk);
      chk_sig("discard", 64'h1, discard);
      chk_sig("fl_rd", 64'h1, frd);
      chk_sig("fl_addr", a, faddr);
      chk_sig("fl_calib", ctl[6], fcal);
      reg_rd(SEL_DATA_LOW, lo);
      reg_rd(SEL_DATA_HIGH, hi);
      chk_sig("word", e, {hi[5:0], lo});
      chk_reg("data_high_top", 8'h00, hi & 8'hc0);
      reg_rd(SEL_CONTROL, lo);
      chk_reg("rd_clear", ctl & 8'hfe | 8'h80, lo);
   endtask

   task automatic wr_word(input logic [11:0] a, input logic [13:0] d, input logic [7:0] ctl,
                          input logic key);
      reg_wr(SEL_ADDR_HIGH, {4'h0, a[11:8]});
      reg_wr(SEL_ADDR_LOW, a[7:0]);
      reg_wr(SEL_DATA_LOW, d[7:0]);
      reg_wr(SEL_DATA_HIGH, {2'h0, d[13:8]});
      if (key) begin
         reg_wr(SEL_UNLOCK, KEY_FIRST);
         reg_wr(SEL_UNLOCK, KEY_SECOND);
      end
      reg_wr(SEL_CONTROL, ctl);
      repeat (2) @(negedge clk);
   endtask

   task automatic wait_wr();
      logic [7:0] c;
      c = 8'hff;
      for (int i = 0; i < 100 && c[1] !== 1'b0; i++) begin
         reg_rd(SEL_CONTROL, c);
      end
      chk_reg("wr_done", 8'h84, c);
   endtask

   task automatic test_done();
      if (miscompares == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      #40000;
      miscompares++;
      test_done();
   end

   initial begin
      repeat (20) @(negedge clk);
      arst_n = 1'b1;
      repeat (5) @(negedge clk);
      for (int s = 0; s < 8; s++) begin
         reg_rd(3'(s), v);
         chk_reg("reset_value", (s == 4) ? 8'h80 : 8'h00, v);
      end
      reg_wr(SEL_DATA_HIGH, 8'hff);
      reg_rd(SEL_DATA_HIGH, v);
      chk_reg("data_high_mask", 8'h3f, v);
      reg_wr(SEL_ADDR_HIGH, 8'hff);
      reg_rd(SEL_ADDR_HIGH, v);
      chk_reg("addr_high_mask", 8'h0f, v);
      reg_wr(SEL_CONTROL, 8'h38);
      reg_rd(SEL_CONTROL, v);
      chk_reg("control_mask", 8'h80, v);
      reg_wr(SEL_UNLOCK, 8'h5a);
      reg_rd(SEL_UNLOCK, v);
      chk_reg("unlock_zero", 8'h00, v);
      for (int k = 0; k < 4; k++) begin
         @(negedge clk);
         cp = k[1];
         ereq = k[0];
         repeat (4) @(negedge clk);
         chk_sig("ext_grant", k[0] & ~k[1], grant);
      end
      // core access from here on runs with code protection on
      flash_read(12'h0a5, 8'h01, pat(12'h0a5));
      flash_read(12'hfff, 8'h01, pat(12'hfff));
      flash_read(12'h003, 8'h41, 14'h2a03);
      reg_wr(SEL_ADDR_LOW, 8'h77);
      reg_rd(SEL_DATA_LOW, v);
      chk_reg("data_held", 8'h03, v);
      wr_word(12'h107, 14'h0, 8'h02, 1'b1);
      reg_rd(SEL_CONTROL, v);
      chk_reg("start_no_allow", 8'h80, v);
      reg_wr(SEL_CONTROL, 8'h04);
      wr_word(12'h107, 14'h0, 8'h46, 1'b1);
      reg_rd(SEL_CONTROL, v);
      chk_reg("start_calib", 8'hc4, v);
      wr_word(12'h107, 14'h0, 8'h06, 1'b0);
      reg_rd(SEL_CONTROL, v);
      chk_reg("start_no_key", 8'h84, v);
      wps = 2'h2;
      wr_word(12'h107, 14'h0, 8'h06, 1'b1);
      reg_rd(SEL_CONTROL, v);
      chk_reg("start_protected", 8'h84, v);
      wps = 2'h1;
      wr_word(12'h7ff, 14'h0, 8'h06, 1'b1);
      reg_rd(SEL_CONTROL, v);
      chk_reg("start_protected_half", 8'h84, v);
      wps = 2'h0;
      wr_word(12'hfff, 14'h0, 8'h06, 1'b1);
      reg_rd(SEL_CONTROL, v);
      chk_reg("start_protected_all", 8'h84, v);
      flash_read(12'h104, 8'h05, pat(12'h104));
      wps = 2'h3;
      chk_sig("refused_no_erase", 64'h0, erase_cnt + stall_cnt);
      for (int i = 0; i < 4; i++) begin
         w[i] = 14'h1230 + 14'(i);
         wr_word(12'h104 + 12'(i), w[i], 8'h06, 1'b1);
         if (i == 3) begin
            reg_rd(SEL_CONTROL, v);
            chk_reg("wr_busy", 8'h86, v);
         end else begin
            chk_sig("no_early_erase", 64'h0, erase_cnt);
         end
         wait_wr();
      end
      chk_sig("erase_count", 64'h1, erase_cnt);
      chk_sig("prog_count", 64'h1, prog_cnt);
      chk_sig("stall_cycles", PCYC, stall_cnt);
      chk_sig("row_addr", 12'h100, row_seen);
      chk_sig("block_data", {w[3], w[2], w[1], w[0]}, wd_seen);
      flash_read(12'h106, 8'h05, w[2]);
      flash_read(12'h10f, 8'h05, 14'h3fff);
      test_done();
   end
endmodule
